// ==== logic/irq_pkg.sv ====
`default_nettype none
package irq_pkg;

  // ****************************************
  // register map (byte offsets)
  // ****************************************
  localparam logic [9:0] CFG_OFS = 10'h054;
  localparam logic [9:0] STS_OFS = 10'h058;
  localparam logic [9:0] EN_OFS = 10'h05c;

  // ****************************************
  // event bit positions, shared by status and enable
  // ****************************************
  localparam int BIT_SW = 31;
  localparam int BIT_READY = 30;
  localparam int BIT_FABRIC = 28;
  localparam int BIT_PORT2 = 27;
  localparam int BIT_PORT1 = 26;
  localparam int BIT_TIMER = 19;
  localparam int BIT_PIN = 12;
  localparam logic [31:0] EVT_MASK = 32'hdc08_1000;
  localparam logic [31:0] W1C_MASK = 32'hc008_0000;
  localparam logic [31:0] STS_RESET = 32'h0000_0000;
  localparam logic [31:0] EN_RESET = 32'h0000_0000;

  // ****************************************
  // configuration register fields
  // ****************************************
  localparam int CFG_QUIET_LSB = 24;
  localparam int CFG_QUIET_W = 8;
  localparam int CFG_CLR = 14;
  localparam int CFG_QSTS = 13;
  localparam int CFG_MASTER = 12;
  localparam int CFG_GATE = 8;
  localparam int CFG_POL = 4;
  localparam int CFG_TYPE = 0;
  localparam logic [7:0] QUIET_RESET = 8'h00;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int QUIET_UNIT_NS = 10000;
  localparam int QUIET_UNIT_CYC = (QUIET_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRESC_W = 11;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [9:0] addr;
    logic [31:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic fabric;
    logic port2;
    logic port1;
    logic pin;
    logic timer_wrap;
  } src_s;

endpackage : irq_pkg
`default_nettype wire

// ==== logic/quiet_timer.sv ====
`timescale 1ns/100ps
`default_nettype none
module quiet_timer
  import irq_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic restart,
  input wire logic [7:0] interval,
  // status
  output logic active
);

  typedef struct packed {
    logic [PRESC_W-1:0] presc;
    logic [7:0] units;
    logic active;
  } qstate_s;

  qstate_s st;
  qstate_s nx;

  localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(QUIET_UNIT_CYC - 1);

  always_comb begin
    nx = st;
    // [RQ16] zero interval cancels
    if (interval == 8'h00) begin
      nx = '0;
    end else if (start || restart) begin
      nx = '0;
      nx.active = 1'b1;
    end else if (st.active) begin
      if (st.presc == PRESC_LAST) begin
        nx.presc = '0;
        nx.units = st.units + 8'h01;
        if (st.units + 8'h01 == interval) begin
          nx.active = 1'b0;
        end
      end else begin
        nx.presc = st.presc + PRESC_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign active = st.active;

  // [RQ16] zero interval releases
  a_quiet_zero: assert property (@(posedge clk_sys) disable iff (rst)
    interval == 8'h00 |=> !active) else $error("quiet interval active with zero setting"); // [RQ16]

endmodule : quiet_timer
`default_nettype wire

// ==== logic/irq_ctrl.sv ====
// How it works
// [RQ1] push-pull polarity bit picks active level
// [RQ2] open-drain always pulls low, ignores polarity
// [RQ3] type bit: zero open-drain, one push-pull
// [RQ4] polarity and type survive soft reset
// [RQ5] status bits set regardless of enables
// [RQ6] writing one clears sticky bits; zero ignored
// [RQ7] software event set by raising trigger enable
// [RQ8] ready bit sets after any reset
// [RQ9] fabric bit mirrors fabric pending input
// [RQ10] two transceiver bits mirror their inputs
// [RQ11] timer wrap sets sticky timer bit
// [RQ12] pin event bit mirrors pin input
// [RQ13] gate bit clear holds pin deasserted
// [RQ14] master bit is OR of enabled status
// [RQ15] enable register shares status bit layout
// [RQ16] quiet interval in ten microsecond units
// [RQ17] reserved bits read zero, ignore writes
`timescale 1ns/100ps
`default_nettype none
module irq_ctrl
  import irq_pkg::*;
(
  // clock and resets
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic soft_rst,
  // register port
  input wire reg_req_s bus,
  output logic [31:0] rd_data,
  // event sources
  input wire src_s src,
  // request pin
  output logic irq_out,
  output logic irq_oe
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] quiet;
    logic deas_clr;
    logic gate;
    logic pol;
    logic drv_type;
    logic [31:0] sts;
    logic [31:0] en;
    logic ready_pend;
    logic pin_req;
    logic irq_out;
    logic irq_oe;
    logic [31:0] rdata;
  } state_s;

  state_s st;
  state_s nx;
  logic quiet_active;
  logic irq_int;
  logic pin_req;

  // [RQ14] enabled status combined
  assign irq_int = |(st.sts & st.en);
  // [RQ13] gate holds pin off
  assign pin_req = irq_int && st.gate && !quiet_active;

  function automatic logic [31:0] read_word(input logic [9:0] addr, input state_s s, input logic qa,
                                            input logic mi);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (addr)
      CFG_OFS: begin
        w[CFG_QUIET_LSB +: CFG_QUIET_W] = s.quiet;
        w[CFG_QSTS] = qa;
        w[CFG_MASTER] = mi;
        w[CFG_GATE] = s.gate;
        w[CFG_POL] = s.pol;
        w[CFG_TYPE] = s.drv_type;
      end
      STS_OFS: w = s.sts & EVT_MASK;
      EN_OFS: w = s.en & EVT_MASK;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction : read_word

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nx = st;
    nx.deas_clr = 1'b0;
    nx.ready_pend = 1'b0;
    nx.pin_req = pin_req;
    if (bus.wr) begin
      case (bus.addr)
        CFG_OFS: begin
          // [RQ17] only defined fields stored
          nx.quiet = bus.wdata[CFG_QUIET_LSB +: CFG_QUIET_W];
          nx.deas_clr = bus.wdata[CFG_CLR];
          nx.gate = bus.wdata[CFG_GATE];
          nx.pol = bus.wdata[CFG_POL];
          nx.drv_type = bus.wdata[CFG_TYPE];
        end
        STS_OFS: begin
          // [RQ6] write one clears
          nx.sts = st.sts & ~(bus.wdata & W1C_MASK);
        end
        EN_OFS: begin
          // [RQ15] same layout as status
          nx.en = bus.wdata & EVT_MASK;
          // [RQ7] trigger raise sets event
          if (bus.wdata[BIT_SW] && !st.en[BIT_SW]) begin
            nx.sts[BIT_SW] = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // sets come after write-one clears so an event coincident with such a clear is never lost; soft reset is applied last and drops it
    // [RQ5] sets ignore enables
    // [RQ8] ready after reset
    if (st.ready_pend) begin
      nx.sts[BIT_READY] = 1'b1;
    end
    // [RQ11] timer wrap sticky
    if (src.timer_wrap) begin
      nx.sts[BIT_TIMER] = 1'b1;
    end
    // [RQ9] fabric mirror
    nx.sts[BIT_FABRIC] = src.fabric;
    // [RQ10] transceiver mirrors
    nx.sts[BIT_PORT2] = src.port2;
    nx.sts[BIT_PORT1] = src.port1;
    // [RQ12] pin event mirror
    nx.sts[BIT_PIN] = src.pin;
    if (bus.rd) begin
      nx.rdata = read_word(bus.addr, st, quiet_active, irq_int);
    end
    // ****************************************
    // pin driver
    // ****************************************
    // [RQ3] type bit picks driver
    if (st.drv_type) begin
      // [RQ1] push-pull polarity
      nx.irq_oe = 1'b1;
      nx.irq_out = st.pol ? pin_req : !pin_req;
    end else begin
      // [RQ2] open-drain pulls low only
      nx.irq_oe = pin_req;
      nx.irq_out = 1'b0;
    end
    if (soft_rst) begin
      // [RQ4] pin setup kept
      nx.quiet = QUIET_RESET;
      nx.deas_clr = 1'b0;
      nx.gate = 1'b0;
      nx.sts = STS_RESET;
      nx.en = EN_RESET;
      nx.ready_pend = 1'b1;
      nx.pin_req = 1'b0;
      nx.pol = st.pol;
      nx.drv_type = st.drv_type;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= '0;
      st.ready_pend <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  // ****************************************
  // quiet interval timer
  // ****************************************
  // [RQ16] starts on request release
  quiet_timer u_quiet (
    .clk_sys(clk_sys),
    .rst(sys_rst || soft_rst),
    .start(st.pin_req && !pin_req),
    .restart(st.deas_clr),
    .interval(st.quiet),
    .active(quiet_active)
  );

  assign rd_data = st.rdata;
  assign irq_out = st.irq_out;
  assign irq_oe = st.irq_oe;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_pp_polarity: assert property (st.drv_type && !soft_rst |=> irq_oe && // [RQ1]
    irq_out == ($past(st.pol) ? $past(pin_req) : !$past(pin_req))) else $error("push-pull level wrong");
  a_od_low_only: assert property (!st.drv_type |=> !irq_out) else $error("open-drain drove high"); // [RQ2]
  a_od_enable: assert property (!st.drv_type |=> irq_oe == $past(pin_req)) else $error("open-drain enable wrong"); // [RQ3]
  a_keep_soft: assert property (soft_rst |=> st.pol == $past(st.pol) && // [RQ4]
    st.drv_type == $past(st.drv_type)) else $error("pin setup lost on soft reset");
  a_w1c_timer: assert property (bus.wr && bus.addr == STS_OFS && bus.wdata[BIT_TIMER] && // [RQ6]
    !src.timer_wrap && !soft_rst |=> !st.sts[BIT_TIMER]) else $error("timer bit not cleared");
  a_sw_set: assert property (bus.wr && bus.addr == EN_OFS && bus.wdata[BIT_SW] && !st.en[BIT_SW] // [RQ7]
    && !soft_rst |=> st.sts[BIT_SW]) else $error("software event not set");
  a_ready_set: assert property (soft_rst ##1 !soft_rst |=> st.sts[BIT_READY]) else $error("ready missing"); // [RQ8]
  a_port_mirror: assert property (!soft_rst |=> // [RQ10]
    st.sts[BIT_PORT2:BIT_PORT1] == {$past(src.port2), $past(src.port1)}) else $error("port mirror wrong");
  a_timer_set: assert property (src.timer_wrap && !soft_rst |=> st.sts[BIT_TIMER]) else $error("wrap lost"); // [RQ11]
  a_gate_off: assert property (!st.gate |=> !st.pin_req) else $error("gated pin asserted"); // [RQ13]
  a_master_read: assert property (bus.rd && bus.addr == CFG_OFS |=> // [RQ14]
    rd_data[CFG_MASTER] == $past(irq_int)) else $error("master bit wrong");
  a_rsvd_zero: assert property (bus.rd && bus.addr == STS_OFS |=> (rd_data & ~EVT_MASK) == 32'h0) // [RQ17]
    else $error("reserved bits nonzero");
  a_quiet_hold: assert property (quiet_active |=> !st.pin_req) else $error("request in quiet interval"); // [RQ16]
  a_quiet_read: assert property (bus.rd && bus.addr == CFG_OFS |=> // [RQ16]
    rd_data[CFG_QSTS] == $past(quiet_active) && !rd_data[CFG_CLR]) else $error("quiet status read wrong");
  a_en_layout: assert property (bus.wr && bus.addr == EN_OFS && !soft_rst |=> // [RQ15]
    st.en == ($past(bus.wdata) & EVT_MASK)) else $error("enable write wrong");
  a_soft_clear: assert property (soft_rst |=> !st.gate && st.quiet == QUIET_RESET && // [RQ4]
    st.en == EN_RESET) else $error("soft reset left setup");
  a_src_mirror: assert property (!soft_rst |=> st.sts[BIT_PIN] == $past(src.pin) && // [RQ9] [RQ12]
    st.sts[BIT_FABRIC] == $past(src.fabric)) else $error("source mirror wrong");

endmodule : irq_ctrl
`default_nettype wire

// ==== verification/irq_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// host side of the request line
// ****************************************
module irq_host_model (
  // pin from the device
  input wire logic irq_out,
  input wire logic irq_oe,
  // level seen by the host
  output logic pin_level
);
  // board pull-up: a released open-drain line floats high, never holds the old value
  assign pin_level = irq_oe ? irq_out : 1'b1;
endmodule : irq_host_model
`default_nettype wire

// ==== verification/system_interrupt_status_and_pin_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module system_interrupt_status_and_pin_bench
  import irq_pkg::*;
;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic soft_rst = 1'b0;
  reg_req_s bus = '0;
  src_s src = '0;
  logic [31:0] rd_data;
  logic irq_out;
  logic irq_oe;
  logic pin_level;
  int err_count = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h0000_0029;
  logic [31:0] exp_q[$];
  logic [1:0] rd_seen = 2'h0;
  logic [31:0] r;
  logic [31:0] e;
  logic [31:0] cfgs [3] = '{32'h0000_0111, 32'h0000_0101, 32'h0000_0110};
  logic lvl [3] = '{1'b1, 1'b0, 1'b0};

  irq_ctrl dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .soft_rst(soft_rst), .bus(bus), .rd_data(rd_data),
    .src(src), .irq_out(irq_out), .irq_oe(irq_oe));
  irq_host_model host_u (.irq_out(irq_out), .irq_oe(irq_oe), .pin_level(pin_level));

  always #4 clk_sys = ~clk_sys;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task chk(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, want);
    end
  endtask : chk

  task summarize();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    #1 bus = '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    #1 bus = '0;
  endtask : wr

  // expectation queued now, compared by the monitor once read data lands
  task rd(input logic [9:0] a, input logic [31:0] want);
    exp_q.push_back(want);
    @(posedge clk_sys);
    #1 bus = '{1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge clk_sys);
    #1 bus = '0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : rd

  // ****************************************
  // read data monitor
  // ****************************************
  // checked at the second falling edge after the read data register loads
  always @(posedge clk_sys) rd_seen <= {rd_seen[0], bus.rd};
  always @(negedge clk_sys) begin
    if (rd_seen[1]) begin
      if (exp_q.size() == 0) begin
        err_count++;
        $display("Error %0t: read data with no expectation", $time);
      end else begin
        chk(rd_data, exp_q.pop_front());
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    summarize();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    tick(2);
    rd(STS_OFS, 32'h4000_0000);
    rd(EN_OFS, 32'h0000_0000);
    wr(STS_OFS, 32'h0000_0000);
    rd(STS_OFS, 32'h4000_0000);
    wr(STS_OFS, 32'h4000_0000);
    rd(STS_OFS, 32'h0000_0000);
    wr(EN_OFS, 32'h8000_0000);
    rd(STS_OFS, 32'h8000_0000);
    wr(STS_OFS, 32'h8000_0000);
    $display("test register basics done");
    for (int i = 0; i < 4; i++) begin
      r = xs();
      src = r[4:0];
      tick(1);
      src.timer_wrap = 1'b0;
      e = (32'(r[4]) << 28) | (32'(r[3]) << 27) | (32'(r[2]) << 26) | (32'(r[1]) << 12) | (32'(r[0]) << 19);
      wr(STS_OFS, 32'h0000_0000);
      rd(STS_OFS, e);
      wr(STS_OFS, 32'hffff_ffff);
      rd(STS_OFS, e & ~W1C_MASK);
    end
    $display("test event sources done");
    wr(CFG_OFS, 32'h00ff_8fff);
    rd(CFG_OFS, 32'h0000_0111);
    rd(10'h060, 32'h0000_0000);
    src = '0;
    wr(EN_OFS, 32'h0000_1000);
    for (int i = 0; i < 3; i++) begin
      wr(CFG_OFS, cfgs[i]);
      tick(1);
      src.pin = 1'b1;
      tick(4);
      chk({31'h0, pin_level}, {31'h0, lvl[i]});
      src.pin = 1'b0;
      tick(4);
      chk({31'h0, pin_level}, {31'h0, ~lvl[i]});
    end
    $display("test pin modes done");
    wr(CFG_OFS, 32'h0000_0011);
    tick(1);
    src.pin = 1'b1;
    tick(4);
    chk({31'h0, pin_level}, 32'h0000_0000);
    rd(CFG_OFS, 32'h0000_1011);
    soft_rst = 1'b1;
    tick(1);
    soft_rst = 1'b0;
    rd(CFG_OFS, 32'h0000_0011);
    rd(STS_OFS, 32'h4000_1000);
    // full reset drops the kept pin setup as well
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    rd(CFG_OFS, 32'h0000_0000);
    rd(STS_OFS, 32'h4000_1000);
    $display("test gate and soft reset done");
    // quiet interval: restart, hold, natural end, start on release, zero release
    wr(EN_OFS, 32'h0000_1000);
    wr(CFG_OFS, 32'h0100_4111);
    tick(3);
    chk({31'h0, pin_level}, 32'h0000_0000);
    rd(CFG_OFS, 32'h0100_3111);
    tick(1300);
    chk({31'h0, pin_level}, 32'h0000_0001);
    src.pin = 1'b0;
    tick(3);
    src.pin = 1'b1;
    tick(4);
    chk({31'h0, pin_level}, 32'h0000_0000);
    wr(CFG_OFS, 32'h0000_0111);
    tick(3);
    chk({31'h0, pin_level}, 32'h0000_0001);
    $display("test quiet interval done");
    summarize();
  end
endmodule : system_interrupt_status_and_pin_bench
`default_nettype wire
